// [verilog/ldc_cfg_bank.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ldc_regs.svh"
module ldc_cfg_bank #(
  parameter int NDEV = 8,
  parameter int NLINE = 16,
  parameter int NCHAN = 4,
  parameter int MISC_W = 6
) (
  // Clock and resets
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic soft_rst_in,
  // Configuration space access
  input wire logic [2:0] cfg_ldn_in,
  input wire logic [7:0] cfg_index_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  output logic [7:0] cfg_rdata_out,
  // Device interrupt sources and gates
  input wire logic [NDEV-1:0] dev_irq_in,
  input wire ldc_pkg::ldc_gate_t gate_in,
  input wire logic serirq_mode_in,
  // Interrupt delivery
  output logic [NLINE-1:0] irq_pin_val_out,
  output logic [NLINE-1:0] irq_pin_oe_out,
  output logic [NLINE-1:0] serirq_level_out,
  // DMA requests
  input wire logic fdc_drq_in,
  input wire logic pp_drq_in,
  output logic [NCHAN-1:0] dma_request_pin_val_out,
  output logic [NCHAN-1:0] dma_request_pin_oe_out,
  // Floppy core control
  input wire logic fdc_io_wr_in,
  input wire logic [2:0] fdc_io_off_in,
  output logic fdc_io_wr_out,
  output logic fdc_core_halt_out,
  output ldc_pkg::ldc_fdc_cfg_t fdc_cfg_out,
  // Floppy drive pins
  input wire ldc_pkg::ldc_fdd_pins_t fdd_core_in,
  input wire logic [MISC_W-1:0] fdd_misc_in,
  output ldc_pkg::ldc_fdd_pins_t fdd_pin_val_out,
  output ldc_pkg::ldc_fdd_pins_t fdd_pin_oe_out,
  output logic [MISC_W-1:0] fdd_misc_val_out,
  output logic [MISC_W-1:0] fdd_misc_oe_out
);
  import ldc_pkg::*;

  // Standard per-device copies; DMA has one slot for floppy and one for parallel.
  ldc_level_t [NDEV-1:0] irq_lvl_r;
  ldc_chan_t [1:0] dma_sel_r;
  // Floppy vendor registers.
  logic [7:0] fmode_r;
  logic [7:0] fopt_r;
  logic [7:0] ftype_r;
  logic [7:0] drive_zero_setup_r;
  logic [7:0] drive_one_setup_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Address decode.
  wire ldn_fdc = (cfg_ldn_in == `LDC_LDN_FDC);
  wire ldn_pp = (cfg_ldn_in == `LDC_LDN_PP);
  wire has_dma = ldn_fdc || ldn_pp;
  wire dma_slot = ldn_pp;
  wire wr_irq = cfg_wr_in && (cfg_index_in == `LDC_IDX_IRQ);
  wire wr_dma = cfg_wr_in && has_dma && (cfg_index_in == `LDC_IDX_DMA);
  wire wr_fdc = cfg_wr_in && ldn_fdc;
  wire wr_fmode = wr_fdc && (cfg_index_in == `LDC_IDX_FMODE);
  wire wr_fopt = wr_fdc && (cfg_index_in == `LDC_IDX_FOPT);
  wire wr_ftype = wr_fdc && (cfg_index_in == `LDC_IDX_FTYPE);
  wire wr_drive_zero_setup = wr_fdc && (cfg_index_in == `LDC_IDX_DRIVE_ZERO_SETUP);
  wire wr_drive_one_setup = wr_fdc && (cfg_index_in == `LDC_IDX_DRIVE_ONE_SETUP);

  // Standard selects follow both hard and soft reset.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || soft_rst_in) begin
      for (int i = 0; i < NDEV; i++) begin
        irq_lvl_r[i] <= `LDC_RST_IRQ;
      end
      dma_sel_r[0] <= `LDC_RST_DMA;
      dma_sel_r[1] <= `LDC_RST_DMA;
    end else begin
      if (wr_irq) begin
        irq_lvl_r[cfg_ldn_in] <= cfg_wdata_in[3:0];
      end
      if (wr_dma) begin
        dma_sel_r[dma_slot] <= cfg_wdata_in[2:0];
      end
    end
  end

  // Vendor registers ignore soft reset so a warm boot keeps drive setup.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      fmode_r <= `LDC_RST_FMODE;
      fopt_r <= `LDC_RST_FOPT;
      ftype_r <= `LDC_RST_FTYPE;
      drive_zero_setup_r <= `LDC_RST_FDD;
      drive_one_setup_r <= `LDC_RST_FDD;
    end else begin
      if (wr_fmode) begin
        fmode_r <= cfg_wdata_in;
      end
      if (wr_fopt) begin
        fopt_r <= cfg_wdata_in & `LDC_FOPT_WMASK;
      end
      if (wr_ftype) begin
        ftype_r <= cfg_wdata_in;
      end
      if (wr_drive_zero_setup) begin
        drive_zero_setup_r <= cfg_wdata_in;
      end
      if (wr_drive_one_setup) begin
        drive_one_setup_r <= cfg_wdata_in;
      end
    end
  end

  // Read mux; every unimplemented location reads zero.
  always_comb begin
    rdata_nxt = 8'h00;
    case (cfg_index_in)
      `LDC_IDX_IRQ: rdata_nxt = {4'h0, irq_lvl_r[cfg_ldn_in]};
      `LDC_IDX_DMA: rdata_nxt = has_dma ? {5'h00, dma_sel_r[dma_slot]} : 8'h00;
      `LDC_IDX_FMODE: rdata_nxt = ldn_fdc ? fmode_r : 8'h00;
      `LDC_IDX_FOPT: rdata_nxt = ldn_fdc ? fopt_r : 8'h00;
      `LDC_IDX_FTYPE: rdata_nxt = ldn_fdc ? ftype_r : 8'h00;
      `LDC_IDX_DRIVE_ZERO_SETUP: rdata_nxt = ldn_fdc ? drive_zero_setup_r : 8'h00;
      `LDC_IDX_DRIVE_ONE_SETUP: rdata_nxt = ldn_fdc ? drive_one_setup_r : 8'h00;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign cfg_rdata_out = rdata_r;

  // Floppy mode fields.
  assign fdc_cfg_out.enhanced_mode = fmode_r[0];
  assign fdc_cfg_out.nonburst_dma = fmode_r[1];
  assign fdc_cfg_out.personality = fmode_r[3:2];
  assign fdc_cfg_out.drive_swap = fmode_r[4];
  assign fdc_cfg_out.shutdown = fmode_r[5];
  assign fdc_cfg_out.push_pull = fmode_r[6];
  assign fdc_cfg_out.outputs_off = fmode_r[7];
  assign fdc_cfg_out.drive_a_type = ftype_r[1:0];
  assign fdc_cfg_out.drive_b_type = ftype_r[3:2];
  assign fdc_cfg_out.drive_zero_type = drive_zero_setup_r[1:0];
  assign fdc_cfg_out.drive_one_type = drive_one_setup_r[1:0];

  // Interrupt gating per device.
  wire pp_svc_block = gate_in.pp_ecp_mode && gate_in.ecp_service_flag;
  wire uart1_on = (|gate_in.uart1_int_enables) && gate_in.uart1_aux_output_two;
  wire second_serial_on = (|gate_in.second_serial_int_enables)
                          && gate_in.second_serial_aux_output_two;
  logic [NDEV-1:0] dev_gate;
  logic [NDEV-1:0] irq_drive;
  logic [NDEV-1:0] irq_req;

  always_comb begin
    dev_gate = '0;
    dev_gate[`LDC_LDN_FDC] = gate_in.floppy_dma_gate;
    dev_gate[`LDC_LDN_PP] = gate_in.pp_irq_gate && !pp_svc_block;
    dev_gate[`LDC_LDN_UART1] = uart1_on;
    dev_gate[`LDC_LDN_SECOND_SERIAL] = second_serial_on;
    dev_gate[`LDC_LDN_RTC] = 1'b1;
    dev_gate[`LDC_LDN_KBD] = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < NDEV; g++) begin : g_req
      assign irq_drive[g] = dev_gate[g] && (irq_lvl_r[g] != `LDC_IRQ_NONE);
      if (g == `LDC_LDN_PP) begin : g_pp
        // Enhanced parallel modes signal low-true on the pin.
        assign irq_req[g] = dev_irq_in[g] ^ gate_in.pp_enh_mode;
      end else begin : g_std
        assign irq_req[g] = dev_irq_in[g];
      end
    end
  endgenerate

  // Per-line routing; line zero never carries a request.
  logic [NLINE-1:0] line_sel;
  logic [NLINE-1:0] line_val;
  assign line_sel[0] = 1'b0;
  assign line_val[0] = 1'b0;
  generate
    for (g = 1; g < NLINE; g++) begin : g_line
      ldc_irq_line #(
        .NDEV(NDEV),
        .LINE(4'(g))
      ) u_line (
        .level_in(irq_lvl_r),
        .drive_in(irq_drive),
        .req_in(irq_req),
        .sel_out(line_sel[g]),
        .val_out(line_val[g])
      );
    end
  endgenerate

  logic [NLINE-1:0] irq_val_r;
  logic [NLINE-1:0] irq_oe_r;
  logic [NLINE-1:0] serirq_r;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      irq_val_r <= '0;
      irq_oe_r <= '0;
      serirq_r <= '0;
    end else begin
      irq_val_r <= line_val;
      irq_oe_r <= serirq_mode_in ? '0 : line_sel;
      serirq_r <= serirq_mode_in ? line_val : '0;
    end
  end
  assign irq_pin_val_out = irq_val_r;
  assign irq_pin_oe_out = irq_oe_r;
  assign serirq_level_out = serirq_r;

  // DMA channels: slot 0 is floppy, slot 1 is parallel port.
  wire [1:0] dma_drive;
  wire [1:0] dma_req = {pp_drq_in, fdc_drq_in};
  assign dma_drive[0] = gate_in.floppy_dma_gate && (dma_sel_r[0] <= `LDC_DMA_LAST);
  assign dma_drive[1] = gate_in.pp_ecp_mode && gate_in.ecp_dma_gate
                        && (dma_sel_r[1] <= `LDC_DMA_LAST);
  logic [NCHAN-1:0] chan_sel;
  logic [NCHAN-1:0] chan_val;
  generate
    for (g = 0; g < NCHAN; g++) begin : g_chan
      ldc_dma_chan #(
        .NDEV(2),
        .CHAN(3'(g))
      ) u_chan (
        .chan_in(dma_sel_r),
        .drive_in(dma_drive),
        .req_in(dma_req),
        .sel_out(chan_sel[g]),
        .val_out(chan_val[g])
      );
    end
  endgenerate

  logic [NCHAN-1:0] drq_val_r;
  logic [NCHAN-1:0] drq_oe_r;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      drq_val_r <= '0;
      drq_oe_r <= '0;
    end else begin
      drq_val_r <= chan_val;
      drq_oe_r <= chan_sel;
    end
  end
  assign dma_request_pin_val_out = drq_val_r;
  assign dma_request_pin_oe_out = drq_oe_r;

  // Floppy core write filter while shut down.
  wire fio_keep = (fdc_io_off_in == `LDC_FIO_DIGITAL_OUTPUT)
                  || (fdc_io_off_in == `LDC_FIO_TAPE_DRIVE)
                  || (fdc_io_off_in == `LDC_FIO_RATE_SELECT)
                  || (fdc_io_off_in == `LDC_FIO_CONFIG_CONTROL);
  assign fdc_io_wr_out = fdc_io_wr_in && (!fmode_r[5] || fio_keep);
  assign fdc_core_halt_out = fmode_r[5];

  // Drive pin values: swap, then forcing of the density outputs.
  ldc_fdd_pins_t pin_nxt;
  ldc_fdd_pins_t pin_oe_nxt;
  logic [1:0] force_sel;
  logic [MISC_W-1:0] misc_oe_nxt;
  assign force_sel = fopt_r[3:2];

  always_comb begin
    pin_nxt = fdd_core_in;
    if (fmode_r[4]) begin
      pin_nxt.drive_select_zero_n = fdd_core_in.drive_select_one_n;
      pin_nxt.drive_select_one_n = fdd_core_in.drive_select_zero_n;
      pin_nxt.motor_on_zero_n = fdd_core_in.motor_on_one_n;
      pin_nxt.motor_on_one_n = fdd_core_in.motor_on_zero_n;
    end
    case (force_sel)
      `LDC_FORCE_ONE: begin
        pin_nxt.density_out_zero = 1'b1;
        pin_nxt.density_out_one = 1'b1;
      end
      `LDC_FORCE_ZERO: begin
        pin_nxt.density_out_zero = 1'b0;
        pin_nxt.density_out_one = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // Open drain only pulls low: the enable follows the inverted level.
  always_comb begin
    if (fmode_r[7]) begin
      pin_oe_nxt = '0;
      misc_oe_nxt = '0;
    end else if (fmode_r[6]) begin
      pin_oe_nxt = '1;
      misc_oe_nxt = fmode_r[5] ? '0 : '1;
    end else begin
      pin_oe_nxt = ~pin_nxt;
      misc_oe_nxt = fmode_r[5] ? '0 : ~fdd_misc_in;
    end
  end

  ldc_fdd_pins_t pin_val_r;
  ldc_fdd_pins_t pin_oe_r;
  logic [MISC_W-1:0] misc_val_r;
  logic [MISC_W-1:0] misc_oe_r;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pin_val_r <= '1;
      pin_oe_r <= '0;
      misc_val_r <= '1;
      misc_oe_r <= '0;
    end else begin
      pin_val_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
      misc_val_r <= fdd_misc_in;
      misc_oe_r <= misc_oe_nxt;
    end
  end
  assign fdd_pin_val_out = pin_val_r;
  assign fdd_pin_oe_out = pin_oe_r;
  assign fdd_misc_val_out = misc_val_r;
  assign fdd_misc_oe_out = misc_oe_r;
endmodule
`default_nettype wire

// [verilog/ldc_regs.svh]
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH

// Configuration space indices.
`define LDC_IDX_IRQ 8'h70
`define LDC_IDX_DMA 8'h74
`define LDC_IDX_FMODE 8'hf0
`define LDC_IDX_FOPT 8'hf1
`define LDC_IDX_FTYPE 8'hf2
`define LDC_IDX_FRSVD 8'hf3
`define LDC_IDX_DRIVE_ZERO_SETUP 8'hf4
`define LDC_IDX_DRIVE_ONE_SETUP 8'hf5

// Logical device numbers.
`define LDC_LDN_FDC 3'h0
`define LDC_LDN_PP 3'h3
`define LDC_LDN_UART1 3'h4
`define LDC_LDN_SECOND_SERIAL 3'h5
`define LDC_LDN_RTC 3'h6
`define LDC_LDN_KBD 3'h7

// Reset values and the FOPT write mask.
`define LDC_RST_IRQ 4'h0
`define LDC_RST_DMA 3'h4
`define LDC_RST_FMODE 8'h0e
`define LDC_RST_FOPT 8'h00
`define LDC_RST_FTYPE 8'hff
`define LDC_RST_FDD 8'h00
`define LDC_FOPT_WMASK 8'hfc

// Field values.
`define LDC_IRQ_NONE 4'h0
`define LDC_DMA_LAST 3'h3
`define LDC_FORCE_ONE 2'h2
`define LDC_FORCE_ZERO 2'h3

// Floppy core register offsets still writable while shut down.
`define LDC_FIO_DIGITAL_OUTPUT 3'h2
`define LDC_FIO_TAPE_DRIVE 3'h3
`define LDC_FIO_RATE_SELECT 3'h4
`define LDC_FIO_CONFIG_CONTROL 3'h7

`endif

// [verilog/ldc_pkg.sv]
package ldc_pkg;

  typedef logic [3:0] ldc_level_t;
  typedef logic [2:0] ldc_chan_t;

  typedef struct packed {
    logic floppy_dma_gate;
    logic pp_irq_gate;
    logic pp_ecp_mode;
    logic pp_enh_mode;
    logic ecp_service_flag;
    logic ecp_dma_gate;
    logic [3:0] uart1_int_enables;
    logic uart1_aux_output_two;
    logic [3:0] second_serial_int_enables;
    logic second_serial_aux_output_two;
  } ldc_gate_t;

  typedef struct packed {
    logic density_out_zero;
    logic density_out_one;
    logic drive_select_zero_n;
    logic drive_select_one_n;
    logic motor_on_zero_n;
    logic motor_on_one_n;
  } ldc_fdd_pins_t;

  typedef struct packed {
    logic enhanced_mode;
    logic nonburst_dma;
    logic [1:0] personality;
    logic drive_swap;
    logic shutdown;
    logic push_pull;
    logic outputs_off;
    logic [1:0] drive_a_type;
    logic [1:0] drive_b_type;
    logic [1:0] drive_zero_type;
    logic [1:0] drive_one_type;
  } ldc_fdc_cfg_t;

endpackage

// [verilog/ldc_irq_line.sv]
`timescale 1ns/1ns
`default_nettype none
module ldc_irq_line #(
  parameter int NDEV = 8,
  parameter logic [3:0] LINE = 4'h1
) (
  // Per-device selection and request
  input wire ldc_pkg::ldc_level_t [NDEV-1:0] level_in,
  input wire logic [NDEV-1:0] drive_in,
  input wire logic [NDEV-1:0] req_in,
  // Line state
  output logic sel_out,
  output logic val_out
);
  import ldc_pkg::*;

  logic [NDEV-1:0] match;

  genvar d;
  generate
    for (d = 0; d < NDEV; d++) begin : g_dev
      assign match[d] = drive_in[d] && (level_in[d] == LINE);
    end
  endgenerate

  // Several devices may share a line; their requests are ORed.
  assign sel_out = |match;
  assign val_out = |(match & req_in);
endmodule
`default_nettype wire

// [verilog/ldc_dma_chan.sv]
`timescale 1ns/1ns
`default_nettype none
module ldc_dma_chan #(
  parameter int NDEV = 2,
  parameter logic [2:0] CHAN = 3'h0
) (
  // Per-device selection and request
  input wire ldc_pkg::ldc_chan_t [NDEV-1:0] chan_in,
  input wire logic [NDEV-1:0] drive_in,
  input wire logic [NDEV-1:0] req_in,
  // Channel state
  output logic sel_out,
  output logic val_out
);
  import ldc_pkg::*;

  logic [NDEV-1:0] match;

  genvar d;
  generate
    for (d = 0; d < NDEV; d++) begin : g_dev
      assign match[d] = drive_in[d] && (chan_in[d] == CHAN);
    end
  endgenerate

  assign sel_out = |match;
  assign val_out = |(match & req_in);
endmodule
`default_nettype wire

// [verif/ldc_cfg_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module ldc_cfg_chk #(
  parameter int NLINE = 16,
  parameter int NCHAN = 4,
  parameter int MISC_W = 6
) (
  // Clock, resets and configuration access
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic soft_rst_in,
  input wire logic [2:0] cfg_ldn_in,
  input wire logic [7:0] cfg_index_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_rdata_out,
  // Interrupt and DMA pins
  input wire logic serirq_mode_in,
  input wire logic [NLINE-1:0] irq_pin_oe_out,
  input wire logic [NCHAN-1:0] dma_request_pin_oe_out,
  // Floppy side
  input wire logic fdc_io_wr_in,
  input wire logic [2:0] fdc_io_off_in,
  input wire logic fdc_io_wr_out,
  input wire logic fdc_core_halt_out,
  input wire ldc_pkg::ldc_fdc_cfg_t fdc_cfg_out,
  input wire ldc_pkg::ldc_fdd_pins_t fdd_core_in,
  input wire ldc_pkg::ldc_fdd_pins_t fdd_pin_val_out,
  input wire ldc_pkg::ldc_fdd_pins_t fdd_pin_oe_out,
  input wire logic [MISC_W-1:0] fdd_misc_oe_out
);
  import ldc_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // Delayed copies let a property compare against the value one cycle back.
  logic [3:0] lvl_r;
  ldc_fdd_pins_t core_r;
  always_ff @(posedge mclk_in) begin
    lvl_r <= cfg_wdata_in[3:0];
    core_r <= fdd_core_in;
  end
  a_rsvd_reads_zero: assert property ((cfg_index_in == 8'hf3 || cfg_index_in == 8'h75)
    |=> cfg_rdata_out == 8'h00) else $error("reserved index read nonzero");
  a_level_read_back: assert property ((cfg_wr_in && cfg_ldn_in == 3'h0 && cfg_index_in == 8'h70
    && !soft_rst_in) ##1 (!cfg_wr_in && cfg_ldn_in == 3'h0 && cfg_index_in == 8'h70)
    |=> cfg_rdata_out == {4'h0, $past(lvl_r)}) else $error("level read back wrong");
  a_serial_pins_off: assert property (serirq_mode_in |=> irq_pin_oe_out == '0)
    else $error("irq pin driven in serial mode");
  a_line_zero_idle: assert property (irq_pin_oe_out[0] == 1'b0)
    else $error("line zero driven");
  a_soft_pins_float: assert property (soft_rst_in |=> ##1
    (irq_pin_oe_out == '0 && dma_request_pin_oe_out == '0)) else $error("pins driven after soft");
  a_halt_write_filter: assert property (fdc_core_halt_out
    && !(fdc_io_off_in inside {3'h2, 3'h3, 3'h4, 3'h7}) |-> !fdc_io_wr_out)
    else $error("write passed while halted");
  a_run_write_pass: assert property (!fdc_core_halt_out |-> fdc_io_wr_out == fdc_io_wr_in)
    else $error("write blocked while running");
  a_halt_misc_float: assert property (fdc_core_halt_out |=> fdd_misc_oe_out == '0)
    else $error("misc pins driven while halted");
  a_off_all_float: assert property (fdc_cfg_out.outputs_off |=>
    (fdd_pin_oe_out == 6'h00 && fdd_misc_oe_out == '0)) else $error("floppy pins not floated");
  a_push_pull_on: assert property (fdc_cfg_out.push_pull && !fdc_cfg_out.outputs_off
    |=> fdd_pin_oe_out == 6'h3f) else $error("push-pull not driving");
  a_swap_selects: assert property (fdc_cfg_out.drive_swap |=>
    fdd_pin_val_out.drive_select_zero_n == core_r.drive_select_one_n) else $error("swap wrong");
  c_level_write: cover property (cfg_wr_in && cfg_index_in == 8'h70);
  c_halt_write: cover property (fdc_core_halt_out && fdc_io_wr_in);
  c_swap_on: cover property (fdc_cfg_out.drive_swap);
endmodule
bind ldc_cfg_bank ldc_cfg_chk #(.NLINE(NLINE), .NCHAN(NCHAN), .MISC_W(MISC_W)) i_chk (
  .mclk_in, .nrst_in, .soft_rst_in, .cfg_ldn_in, .cfg_index_in, .cfg_wdata_in, .cfg_wr_in,
  .cfg_rdata_out, .serirq_mode_in, .irq_pin_oe_out, .dma_request_pin_oe_out, .fdc_io_wr_in,
  .fdc_io_off_in, .fdc_io_wr_out, .fdc_core_halt_out, .fdc_cfg_out, .fdd_core_in,
  .fdd_pin_val_out, .fdd_pin_oe_out, .fdd_misc_oe_out);
`default_nettype wire

// [verif/ldc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ldc_host_model (
  // Clock and read data
  input wire logic mclk_in,
  input wire logic [7:0] cfg_rdata_in,
  // Configuration space access
  output logic [2:0] cfg_ldn_out,
  output logic [7:0] cfg_index_out,
  output logic [7:0] cfg_wdata_out,
  output logic cfg_wr_out
);
  initial begin
    cfg_ldn_out = 3'h0;
    cfg_index_out = 8'h00;
    cfg_wdata_out = 8'h00;
    cfg_wr_out = 1'b0;
  end
  task automatic wr(input logic [2:0] l, input logic [7:0] i, input logic [7:0] d);
    @(posedge mclk_in);
    #10;
    cfg_ldn_out = l;
    cfg_index_out = i;
    cfg_wdata_out = d;
    cfg_wr_out = 1'b1;
    @(posedge mclk_in);
    #10;
    cfg_wr_out = 1'b0;
    // Stale data is inverted so nothing can rely on it lingering.
    cfg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [2:0] l, input logic [7:0] i, output logic [7:0] d);
    @(posedge mclk_in);
    #10;
    cfg_ldn_out = l;
    cfg_index_out = i;
    @(posedge mclk_in);
    #10;
    d = cfg_rdata_in;
  endtask
  // Writes the level, then index f1 on the parallel device; f1 decodes only for the floppy device, so that second write is ignored.
  task automatic set_pp_irq(input logic [3:0] lvl, input logic [7:0] shadow);
    wr(3'h3, 8'h70, {4'h0, lvl});
    wr(3'h3, 8'hf1, shadow);
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ldc_pkg::*;
  logic mclk_in, nrst_in, soft_rst_in, cfg_wr_in, serirq_mode_in, fdc_drq_in, pp_drq_in;
  logic fdc_io_wr_in, fdc_io_wr_out, fdc_core_halt_out;
  logic [2:0] cfg_ldn_in, fdc_io_off_in;
  logic [7:0] cfg_index_in, cfg_wdata_in, cfg_rdata_out, dev_irq_in;
  logic [15:0] irq_pin_val_out, irq_pin_oe_out, serirq_level_out;
  logic [3:0] dma_request_pin_val_out, dma_request_pin_oe_out;
  logic [5:0] fdd_misc_in, fdd_misc_val_out, fdd_misc_oe_out;
  ldc_gate_t gate_in;
  ldc_fdc_cfg_t fdc_cfg_out;
  ldc_fdd_pins_t fdd_core_in, fdd_pin_val_out, fdd_pin_oe_out;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  ldc_cfg_bank i_dut (.mclk_in, .nrst_in, .soft_rst_in, .cfg_ldn_in, .cfg_index_in,
    .cfg_wdata_in, .cfg_wr_in, .cfg_rdata_out, .dev_irq_in, .gate_in, .serirq_mode_in,
    .irq_pin_val_out, .irq_pin_oe_out, .serirq_level_out, .fdc_drq_in, .pp_drq_in,
    .dma_request_pin_val_out, .dma_request_pin_oe_out, .fdc_io_wr_in, .fdc_io_off_in,
    .fdc_io_wr_out, .fdc_core_halt_out, .fdc_cfg_out, .fdd_core_in, .fdd_misc_in,
    .fdd_pin_val_out, .fdd_pin_oe_out, .fdd_misc_val_out, .fdd_misc_oe_out);
  ldc_host_model i_host (.mclk_in, .cfg_rdata_in(cfg_rdata_out), .cfg_ldn_out(cfg_ldn_in),
    .cfg_index_out(cfg_index_in), .cfg_wdata_out(cfg_wdata_in), .cfg_wr_out(cfg_wr_in));
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      $display("MISMATCH %0t timeout", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] l, input logic [7:0] i, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(l, i, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #10;
  endtask
  initial begin
    {nrst_in, soft_rst_in, serirq_mode_in, fdc_drq_in, pp_drq_in, fdc_io_wr_in} = 6'h00;
    fdc_io_off_in = 3'h0;
    dev_irq_in = 8'h00;
    gate_in = '0;
    fdd_core_in = 6'h05;
    fdd_misc_in = 6'h15;
    repeat (4) @(posedge mclk_in);
    #10;
    nrst_in = 1'b1;
    rchk(3'h0, 8'h70, 8'h00);
    rchk(3'h0, 8'h74, 8'h04);
    rchk(3'h0, 8'hf0, 8'h0e);
    rchk(3'h0, 8'hf1, 8'h00);
    rchk(3'h0, 8'hf2, 8'hff);
    rchk(3'h0, 8'hf4, 8'h00);
    rchk(3'h0, 8'hf5, 8'h00);
    chk(16'({fdc_cfg_out.enhanced_mode, fdc_cfg_out.nonburst_dma}), 16'h1);
    chk(16'(fdc_cfg_out.personality), 16'h3);
    chk(16'({fdc_cfg_out.drive_a_type, fdc_cfg_out.drive_b_type,
      fdc_cfg_out.drive_zero_type, fdc_cfg_out.drive_one_type}), 16'hf0);
    i_host.wr(3'h0, 8'h70, 8'h16);
    i_host.set_pp_irq(4'h7, 8'h08);
    rchk(3'h0, 8'h70, 8'h06);
    rchk(3'h3, 8'h70, 8'h07);
    i_host.wr(3'h4, 8'h74, 8'h02);
    rchk(3'h4, 8'h74, 8'h00);
    i_host.wr(3'h0, 8'h75, 8'hff);
    rchk(3'h0, 8'h75, 8'h00);
    i_host.wr(3'h0, 8'hf1, 8'hff);
    rchk(3'h0, 8'hf1, 8'hfc);
    i_host.wr(3'h0, 8'hf1, 8'h00);
    i_host.wr(3'h0, 8'hf3, 8'hff);
    rchk(3'h0, 8'hf3, 8'h00);
    dev_irq_in = 8'h19;
    tick(2);
    chk(irq_pin_oe_out, 16'h0000);
    gate_in.floppy_dma_gate = 1'b1;
    gate_in.pp_irq_gate = 1'b1;
    tick(2);
    chk(irq_pin_oe_out, 16'h00c0);
    chk(irq_pin_val_out, 16'h00c0);
    {gate_in.pp_ecp_mode, gate_in.ecp_service_flag} = 2'h3;
    tick(2);
    chk(irq_pin_oe_out, 16'h0040);
    {gate_in.ecp_service_flag, gate_in.pp_enh_mode} = 2'h1;
    tick(2);
    chk(irq_pin_val_out, 16'h0040);
    i_host.wr(3'h4, 8'h70, 8'h04);
    gate_in.uart1_aux_output_two = 1'b1;
    tick(2);
    chk(irq_pin_oe_out, 16'h00c0);
    gate_in.uart1_int_enables = 4'h8;
    tick(2);
    chk(irq_pin_oe_out, 16'h00d0);
    i_host.wr(3'h5, 8'h70, 8'h09);
    gate_in.second_serial_int_enables = 4'h1;
    gate_in.second_serial_aux_output_two = 1'b1;
    tick(2);
    chk(irq_pin_oe_out, 16'h02d0);
    serirq_mode_in = 1'b1;
    tick(2);
    chk(irq_pin_oe_out, 16'h0000);
    chk(serirq_level_out & 16'h0050, 16'h0050);
    serirq_mode_in = 1'b0;
    i_host.wr(3'h0, 8'h74, 8'h02);
    i_host.wr(3'h3, 8'h74, 8'h01);
    {fdc_drq_in, pp_drq_in} = 2'h3;
    tick(2);
    chk(16'(dma_request_pin_oe_out), 16'h4);
    chk(16'(dma_request_pin_val_out), 16'h4);
    gate_in.ecp_dma_gate = 1'b1;
    tick(2);
    chk(16'(dma_request_pin_oe_out), 16'h6);
    i_host.wr(3'h0, 8'h74, 8'h07);
    tick(2);
    chk(16'(dma_request_pin_oe_out), 16'h2);
    i_host.wr(3'h0, 8'hf0, 8'h5e);
    soft_rst_in = 1'b1;
    tick(1);
    soft_rst_in = 1'b0;
    rchk(3'h0, 8'h70, 8'h00);
    rchk(3'h0, 8'hf0, 8'h5e);
    chk(irq_pin_oe_out, 16'h0000);
    chk(16'(dma_request_pin_oe_out), 16'h0000);
    rchk(3'h3, 8'h74, 8'h04);
    chk(16'(fdd_pin_val_out), 16'h0a);
    chk(16'(fdd_pin_oe_out), 16'h3f);
    i_host.wr(3'h0, 8'hf1, 8'h08);
    tick(2);
    chk(16'(fdd_pin_val_out), 16'h3a);
    i_host.wr(3'h0, 8'hf1, 8'h0c);
    tick(2);
    chk(16'(fdd_pin_val_out), 16'h0a);
    i_host.wr(3'h0, 8'hf0, 8'h1e);
    tick(2);
    chk(16'(fdd_pin_oe_out), 16'h35);
    i_host.wr(3'h0, 8'hf0, 8'h3e);
    tick(2);
    chk(16'({fdc_core_halt_out, fdd_misc_oe_out}), 16'h40);
    chk(16'(fdd_misc_val_out), 16'h15);
    {fdc_io_wr_in, fdc_io_off_in} = 4'hd;
    tick(1);
    chk(16'(fdc_io_wr_out), 16'h0);
    fdc_io_off_in = 3'h7;
    tick(1);
    chk(16'(fdc_io_wr_out), 16'h1);
    fdc_io_wr_in = 1'b0;
    i_host.wr(3'h0, 8'hf0, 8'h8e);
    tick(2);
    chk(16'({fdd_pin_oe_out, fdd_misc_oe_out}), 16'h0);
    nrst_in = 1'b0;
    tick(1);
    nrst_in = 1'b1;
    rchk(3'h0, 8'hf0, 8'h0e);
    rchk(3'h0, 8'hf1, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
